// ---- logic/pmtu_consts.vh ----
/*
  constants for the page map translation unit: address fields, map entry
  layout and status encodings.
  assumes a 24-bit word-addressed processor bus with bit 0 absent.
*/
`ifndef PMTU_CONSTS_VH
`define PMTU_CONSTS_VH
`define PMTU_PAGE_COUNT 1024
`define PMTU_PAGE_BYTES 4096
`define PMTU_VPI_HI 21
`define PMTU_VPI_LO 12
`define PMTU_OFS_HI 11
`define PMTU_OFS_LO 1
`define PMTU_ROWSEL_HI 19
`define PMTU_ROWSEL_LO 12
`define PMTU_EXP_BIT 21
`define PMTU_ENT_PPN_HI 9
`define PMTU_ENT_PPN_LO 0
`define PMTU_ENT_PS_LO 10
`define PMTU_ENT_PS_HI 11
`define PMTU_ENT_SPARE_LO 12
`define PMTU_ENT_SPARE_HI 14
`define PMTU_ENT_WE 15
`define PMTU_MAP_WIN 2'b01
`define PMTU_PROG_WIN 2'b00
`define PMTU_ST_ABSENT 2'b00
`define PMTU_ST_PRESENT 2'b01
`define PMTU_ST_ACCESSED 2'b10
`define PMTU_ST_DIRTY 2'b11
`define PMTU_ENTRY_RESET 16'h0000
`endif

// ---- logic/pmtu_status_next.v ----
/*
  computes the raised page status for a legal access.
  assumes the caller only applies it on legal RAM accesses.
*/
`include "pmtu_consts.vh"
module pmtu_status_next (
    input wire [1:0] CUR,
    input wire WRITE,
    output reg [1:0] NEXT
);
    always @* begin
        NEXT = CUR;
        if (WRITE) begin
            NEXT = `PMTU_ST_DIRTY;
        end else if (CUR == `PMTU_ST_PRESENT) begin
            NEXT = `PMTU_ST_ACCESSED;
        end
    end
endmodule // pmtu_status_next

// ---- logic/pmtu_translate.v ----
/*
  page map translation unit: 1024-entry map, translation, status update,
  fault generation, column strobe inhibit and RAM row select.
  assumes one bus master at a time presents a stable address and strobe;
  map writes are made in supervisor mode.
*/
// Behaviour
// - translate only when address bits 23 and 22 are both zero
// - 1024 entries indexed by virtual address bits 21..12
// - 4 MB virtual space in 4096 byte pages, offset untranslated
// - physical word address is mapped page plus address bits 11..1
// - entry gives page number, five status bits and write enable; bit 15 is stored but never blocks a write
// - mapped bits 12..19 go to the memory address multiplexers
// - mapped bit 21 picks base or expansion memory
// - bit 21 zero enables base, one enables expansion memory
// - status 00 absent, 01 present, 10 accessed, 11 dirty
// - status updated on every legal access, processor or DMA
// - absent page inhibits access and raises fault as bus error
// - page fault outranks ordinary interrupt requests
// - column strobe suppressed while a management error stands
// - processor may write new status into map entries
// - three spare status bits stored with no hardware effect
// - processor and DMA addresses share the same translation
// - two rows of 1MB: bank bit 0 row Y, 1 row Z
`include "pmtu_consts.vh"
module pmtu_translate (
    input wire CLOCK,
    input wire ARST_N,
    input wire [23:1] PROC_ADDR,
    input wire PROC_STROBE,
    input wire PROC_WRITE,
    input wire FUNCTION_CODE_SUPERVISOR_BIT,
    input wire [15:0] PROC_WDATA,
    input wire [23:1] DMA_ADDR,
    input wire DMA_STROBE,
    input wire DMA_WRITE,
    input wire DMA_GRANT,
    input wire INT_REQ,
    output reg [15:0] MAP_RDATA,
    output reg MAP_ACK,
    output reg [20:1] PHYS_ADDR,
    output reg [7:0] ROW_ADDR_BITS,
    output reg BASE_MEM_EN,
    output reg EXP_MEM_EN,
    output reg ROW_Y_SEL,
    output reg ROW_Z_SEL,
    output reg RAM_ACCESS,
    output reg PAGE_FAULT_ERROR,
    output wire BUS_ERROR_LINE_N,
    output wire COLUMN_STROBE_INHIBIT_N,
    output wire INT_TAKE,
    output reg [1:0] PAGE_STATUS,
    output reg [2:0] SPARE_STATUS
);
    reg [15:0] map_q [0:`PMTU_PAGE_COUNT-1];
    reg fault_q;
    reg fault_d;
    reg ram_access_d;
    reg map_ack_d;
    reg [15:0] map_rdata_d;
    reg [20:1] phys_addr_d;
    reg [7:0] row_addr_bits_d;
    reg base_mem_en_d;
    reg exp_mem_en_d;
    reg row_y_sel_d;
    reg row_z_sel_d;
    reg [1:0] page_status_d;
    reg [2:0] spare_status_d;

    wire bank_sel;
    wire take;
    wire [23:1] addr;
    wire wr;
    wire strobe;
    wire prog_win;
    wire map_win;
    wire [9:0] vpi;
    wire [9:0] map_idx;
    wire [15:0] entry;
    wire [9:0] mapped_page_number;
    wire [1:0] st;
    wire legal;
    wire fault_now;
    wire map_wr;
    wire [1:0] st_next;
    integer i;

    function [9:0] page_of;
        input [23:1] a;
        begin
            page_of = a[`PMTU_VPI_HI:`PMTU_VPI_LO];
        end
    endfunction

    function in_window;
        input [23:1] a;
        input [1:0] w;
        begin
            in_window = (a[23:22] == w);
        end
    endfunction

    function is_absent;
        input [1:0] s;
        begin
            is_absent = (s == `PMTU_ST_ABSENT);
        end
    endfunction

    // both masters feed one translator
    assign addr = DMA_GRANT ? DMA_ADDR : PROC_ADDR;
    assign wr = DMA_GRANT ? DMA_WRITE : PROC_WRITE;
    assign strobe = DMA_GRANT ? DMA_STROBE : PROC_STROBE;
    assign prog_win = in_window(addr, `PMTU_PROG_WIN);
    // map window is processor-only and supervisor-qualified
    assign map_win = !DMA_GRANT && in_window(addr, `PMTU_MAP_WIN) &&
                     FUNCTION_CODE_SUPERVISOR_BIT;
    assign take = strobe && prog_win;
    assign bank_sel = addr[1];
    assign vpi = page_of(addr);
    assign map_idx = addr[10:1];
    assign entry = map_q[vpi];
    assign mapped_page_number = entry[`PMTU_ENT_PPN_HI:`PMTU_ENT_PPN_LO];
    assign st = entry[`PMTU_ENT_PS_HI:`PMTU_ENT_PS_LO];
    // lookup is combinational so the check is ready before column time
    assign fault_now = strobe && prog_win &&
                       is_absent(st);
    assign legal = strobe && prog_win && !fault_now;
    assign map_wr = PROC_STROBE && PROC_WRITE && map_win;

    pmtu_status_next u_next (
        .CUR(st),
        .WRITE(wr),
        .NEXT(st_next)
    );

    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (i = 0; i < `PMTU_PAGE_COUNT; i = i + 1) begin
                map_q[i] <= `PMTU_ENTRY_RESET;
            end
        end else if (map_wr) begin
            map_q[map_idx] <= PROC_WDATA;
        end else if (legal) begin
            map_q[vpi][`PMTU_ENT_PS_HI:`PMTU_ENT_PS_LO] <= st_next;
        end
    end

    // next values of every registered output
    always @* begin
        fault_d = fault_now;
        ram_access_d = legal;
        map_ack_d = PROC_STROBE && map_win && !DMA_GRANT;
        map_rdata_d = map_q[map_idx];
        phys_addr_d = PHYS_ADDR;
        row_addr_bits_d = ROW_ADDR_BITS;
        page_status_d = PAGE_STATUS;
        spare_status_d = SPARE_STATUS;
        base_mem_en_d = 1'b0;
        exp_mem_en_d = 1'b0;
        row_y_sel_d = 1'b0;
        row_z_sel_d = 1'b0;
        if (take) begin
            phys_addr_d = {mapped_page_number[8:0],
                           addr[`PMTU_OFS_HI:`PMTU_OFS_LO]};
            row_addr_bits_d = mapped_page_number[7:0];
            base_mem_en_d = legal && !mapped_page_number[9];
            exp_mem_en_d = legal && mapped_page_number[9];
            row_y_sel_d = legal && !bank_sel;
            row_z_sel_d = legal && bank_sel;
            page_status_d = legal ? st_next : st;
            spare_status_d = entry[`PMTU_ENT_SPARE_HI:`PMTU_ENT_SPARE_LO];
        end
    end

    // fault flag behind the bus error line
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    // page fault toward the processor
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            PAGE_FAULT_ERROR <= 1'b0;
        end else begin
            PAGE_FAULT_ERROR <= fault_d;
        end
    end

    // legal program access marker
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            RAM_ACCESS <= 1'b0;
        end else begin
            RAM_ACCESS <= ram_access_d;
        end
    end

    // map access acknowledge
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            MAP_ACK <= 1'b0;
        end else begin
            MAP_ACK <= map_ack_d;
        end
    end

    // map entry read back
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            MAP_RDATA <= 16'h0000;
        end else begin
            MAP_RDATA <= map_rdata_d;
        end
    end

    // physical word address
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            PHYS_ADDR <= 20'h00000;
        end else begin
            PHYS_ADDR <= phys_addr_d;
        end
    end

    // mapped bits toward the address multiplexers
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ROW_ADDR_BITS <= 8'h00;
        end else begin
            ROW_ADDR_BITS <= row_addr_bits_d;
        end
    end

    // base memory enable
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            BASE_MEM_EN <= 1'b0;
        end else begin
            BASE_MEM_EN <= base_mem_en_d;
        end
    end

    // expansion memory enable
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            EXP_MEM_EN <= 1'b0;
        end else begin
            EXP_MEM_EN <= exp_mem_en_d;
        end
    end

    // row y select
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ROW_Y_SEL <= 1'b0;
        end else begin
            ROW_Y_SEL <= row_y_sel_d;
        end
    end

    // row z select
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ROW_Z_SEL <= 1'b0;
        end else begin
            ROW_Z_SEL <= row_z_sel_d;
        end
    end

    // status of the page after the access
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            PAGE_STATUS <= 2'b00;
        end else begin
            PAGE_STATUS <= page_status_d;
        end
    end

    // spare status bits, shown only
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            SPARE_STATUS <= 3'b000;
        end else begin
            SPARE_STATUS <= spare_status_d;
        end
    end

    assign BUS_ERROR_LINE_N = !fault_q;
    assign COLUMN_STROBE_INHIBIT_N = !(fault_q || fault_now);
    assign INT_TAKE = INT_REQ && !fault_q && !fault_now;
endmodule // pmtu_translate

// ---- tb/pmtu_chk.sv ----
/* port checker for the page map unit.
   assumes it is bound into pmtu_translate, ports matched by name. */
module pmtu_chk (
    input wire CLOCK, ARST_N, PROC_STROBE, PROC_WRITE, DMA_GRANT,
    input wire FUNCTION_CODE_SUPERVISOR_BIT, MAP_ACK, RAM_ACCESS,
    input wire [23:1] PROC_ADDR,
    input wire [20:1] PHYS_ADDR,
    input wire [7:0] ROW_ADDR_BITS,
    input wire BASE_MEM_EN, EXP_MEM_EN, ROW_Y_SEL, ROW_Z_SEL, INT_TAKE,
    input wire PAGE_FAULT_ERROR, BUS_ERROR_LINE_N, COLUMN_STROBE_INHIBIT_N,
    input wire [1:0] PAGE_STATUS
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    sequence prog_take;
        PROC_STROBE && !DMA_GRANT && PROC_ADDR[23:22] == 2'b00;
    endsequence
    sequence map_take;
        PROC_STROBE && !DMA_GRANT && FUNCTION_CODE_SUPERVISOR_BIT
            && PROC_ADDR[23:22] == 2'b01;
    endsequence
    fault_bus_a: assert property (PAGE_FAULT_ERROR |->
        !BUS_ERROR_LINE_N && !RAM_ACCESS) else $error("fault bus");
    fault_cas_a: assert property (PAGE_FAULT_ERROR |->
        !COLUMN_STROBE_INHIBIT_N) else $error("fault cas");
    fault_int_a: assert property (PAGE_FAULT_ERROR |->
        !INT_TAKE) else $error("fault int");
    mem_one_a: assert property (RAM_ACCESS |->
        BASE_MEM_EN != EXP_MEM_EN) else $error("mem enable");
    row_bits_a: assert property (RAM_ACCESS |->
        ROW_ADDR_BITS == PHYS_ADDR[19:12]) else $error("row bits");
    row_sel_a: assert property (RAM_ACCESS |->
        ROW_Z_SEL == PHYS_ADDR[1] && ROW_Y_SEL != ROW_Z_SEL)
        else $error("row select");
    ofs_pass_a: assert property (prog_take ##1 RAM_ACCESS |->
        PHYS_ADDR[11:1] == $past(PROC_ADDR[11:1])) else $error("offset");
    wr_dirty_a: assert property ((prog_take ##0 PROC_WRITE) ##1
        RAM_ACCESS |-> PAGE_STATUS == 2'b11) else $error("dirty");
    window_a: assert property (!DMA_GRANT && PROC_ADDR[23:22] != 2'b00
        |=> !RAM_ACCESS && !PAGE_FAULT_ERROR) else $error("window");
    map_ack_a: assert property (map_take |=> MAP_ACK)
        else $error("map ack");
endmodule // pmtu_chk
bind pmtu_translate pmtu_chk u_chk (.*);

// ---- tb/pmtu_master.sv ----
/* bus master model: processor or dma request, held over one edge.
   assumes the caller sequences start and stop between clock edges. */
module pmtu_master (
    input wire CLOCK,
    output reg [23:1] PA = 23'h0, DA = 23'h0,
    output reg [15:0] WD = 16'h0,
    output reg PS = 1'b0, PW = 1'b0, DS = 1'b0, DW = 1'b0,
    output reg GNT = 1'b0, FC = 1'b1
);
    task start(input d, input w, input [23:1] a, input [15:0] v);
        begin
            @(negedge CLOCK);
            GNT = d;
            FC = 1'b1;
            {PA, PW, PS} = {a, w, !d};
            {DA, DW, DS} = {a, w, d};
            WD = v;
            #1;
        end
    endtask
    task stop;
        begin
            @(negedge CLOCK);
            {PS, DS} = 2'b00;
            {PA, DA, WD} = ~{PA, DA, WD};
        end
    endtask
endmodule // pmtu_master

// ---- tb/tb_top.sv ----
/* self-checking bench for the page map unit.
   assumes a 20 MHz clock and an active low asynchronous reset. */
`include "pmtu_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    reg CLOCK = 1'b0;
    reg ARST_N = 1'b0;
    reg INT_REQ = 1'b1;
    integer bad_count = 0;
    integer check_count = 0;
    wire [23:1] pa, da;
    wire [15:0] wd, rd;
    wire [20:1] phys;
    wire [7:0] rowb;
    wire [1:0] st;
    wire [2:0] sp;
    wire ps, pw, ds, dw, gnt, fc, ack, be, ee, rz, ra, pf, ber_n, inh_n, it;
    wire ry;
    localparam [23:1] VA = {2'b00, 10'h3ff, 11'h155};
    pmtu_master m (.CLOCK(CLOCK), .PA(pa), .DA(da), .WD(wd), .PS(ps),
        .PW(pw), .DS(ds), .DW(dw), .GNT(gnt), .FC(fc));
    pmtu_translate dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .PROC_ADDR(pa),
        .PROC_STROBE(ps), .PROC_WRITE(pw), .FUNCTION_CODE_SUPERVISOR_BIT(fc),
        .PROC_WDATA(wd), .DMA_ADDR(da), .DMA_STROBE(ds), .DMA_WRITE(dw),
        .DMA_GRANT(gnt), .INT_REQ(INT_REQ), .MAP_RDATA(rd), .MAP_ACK(ack),
        .PHYS_ADDR(phys), .ROW_ADDR_BITS(rowb), .BASE_MEM_EN(be),
        .EXP_MEM_EN(ee), .ROW_Y_SEL(ry), .ROW_Z_SEL(rz), .RAM_ACCESS(ra),
        .PAGE_FAULT_ERROR(pf), .BUS_ERROR_LINE_N(ber_n),
        .COLUMN_STROBE_INHIBIT_N(inh_n), .INT_TAKE(it), .PAGE_STATUS(st),
        .SPARE_STATUS(sp));
    always #25 CLOCK = ~CLOCK;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task t_fault;
        begin
            m.start(0, 0, VA, 16'h0);
            chk(inh_n, 0);
            m.stop;
            chk({pf, ber_n, ra, it}, 4'b1000);
        end
    endtask
    task t_map;
        begin
            m.start(0, 1, 23'h2003ff, 16'hd6a3);
            m.stop;
            chk(ack, 1);
            m.start(0, 0, 23'h2003ff, 16'h0);
            m.stop;
            chk(rd, 16'hd6a3);
        end
    endtask
    task t_read;
        begin
            m.start(0, 0, VA, 16'h0);
            chk(inh_n, 1);
            m.stop;
            chk(phys, {9'h0a3, 11'h155});
            chk({rowb, be, ee}, {8'ha3, 2'b01});
            chk({ry, rz}, 2'b01);
            chk({st, sp}, {`PMTU_ST_ACCESSED, 3'b101});
            chk(it, 1);
        end
    endtask
    task t_dma;
        begin
            m.start(1, 1, VA, 16'h0);
            m.stop;
            chk(st, `PMTU_ST_DIRTY);
            m.start(1, 0, VA, 16'h0);
            m.stop;
            chk({st, ra}, {`PMTU_ST_DIRTY, 1'b1});
            m.start(0, 0, {2'b10, VA[21:1]}, 16'h0);
            m.stop;
            chk({ra, pf}, 2'b00);
            m.start(0, 1, 23'h2003ff, 16'h82a3);
            m.stop;
            m.start(0, 0, VA, 16'h0);
            m.stop;
            chk({pf, ra}, 2'b10);
        end
    endtask
    task tally_and_finish;
        begin
            if (bad_count == 0 && check_count > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge CLOCK);
        @(negedge CLOCK);
        ARST_N = 1'b1;
        t_fault;
        t_map;
        t_read;
        t_dma;
        tally_and_finish;
    end
    initial begin
        #10000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
endmodule // tb_top
